// >>> rtl/dbtl_device.sv
// What this block does
// - Allow set: a pending write may pass reads
// - Allow clear: tenures follow address order
// - Far side raises allow by the grant
// - Allow sampled only with a qualified grant
// - Allow with no write: take next read
// - Far side may drop allow after grant
// - Qualified grant with work: become master, busy
// - Busy asserted the cycle after grant
// - Busy negated after last ack, then released
// - Busy from others keeps device off bus
// - Streaming systems ignore the busy input; this block always waits for busy negated
// - 64-bit bus, lanes 0 to 7 high-first
// - Direct-store uses only the high half
// - Single beat noncached, four beats burst
// - Writes drive only selected lanes valid
// - First beat with busy, advance after ack
// - Write lines released after last ack
// - Read data valid with its ack
// - Odd parity per lane, timed as data
// - Non-direct-store reads check parity on all lanes
// - Direct-store reads check high four only
// - Enabled parity error raises machine check
// - Grant qualified: busy, retries all negated
// - Error pin two clocks after ack, one wide
`timescale 1ns/100ps
`default_nettype none
module dbtl_device
   import dbtl_pkg::*;
#(
   parameter int DEPTH = 4
)(
   // Clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_srst,
   // Tenure requests, in address order
   input  wire logic         i_req_valid,
   input  wire logic         i_req_write,
   input  wire logic         i_req_dstore,
   input  wire logic         i_req_burst,
   input  wire dbtl_lanes_t  i_req_lanes,
   input  wire dbtl_line_t   i_req_data,
   output logic              o_req_ready,
   // Read data and completions
   output logic              o_rd_valid,
   output dbtl_dword_t       o_rd_data,
   output logic              o_rd_last,
   output logic              o_wr_done,
   // Parity checking
   input  wire logic         i_parity_check_en,
   output logic              o_machine_check,
   // Bus
   dbtl_if.device            bus
);

   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2) begin : g_depth_check
      $error("dbtl_device: DEPTH must be at least 2");
   end

   typedef enum logic [1:0] {DEV_IDLE, DEV_XFER, DEV_RELEASE} dbtl_dev_e;

   dbtl_dev_e           state_reg, state_next;
   // Pending tenures; entry 0 is the oldest
   dbtl_ten_s           q_reg [DEPTH];
   dbtl_ten_s           q_next [DEPTH];
   logic [CW-1:0]       cnt_reg, cnt_next, cnt_after;
   logic                ready_next;
   logic [IW-1:0]       wr_idx, pick;
   logic                wr_found, qual, pop, push;

   always_comb begin
      wr_idx   = '0;
      wr_found = 1'b0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (i < int'(cnt_reg) && q_reg[i].wr) begin
            wr_idx   = IW'(i);
            wr_found = 1'b1;
         end
      end
      qual = bus.data_bus_grant && !bus.data_bus_busy &&
             !bus.data_retry && !bus.address_retry;
      pop  = qual && state_reg == DEV_IDLE && cnt_reg != '0;
      // Allow only counts on the qualified-grant clock
      pick = (pop && bus.write_reorder_allow && wr_found) ? wr_idx
                                                          : '0;
      push = i_req_valid && o_req_ready;
      cnt_after = cnt_reg - CW'(pop);
      for (int i = 0; i < DEPTH; i++) begin
         q_next[i] = (pop && i >= int'(pick) && i < DEPTH - 1) ? q_reg[i + 1]
                                                             : q_reg[i];
      end
      if (push) begin
         q_next[cnt_after[IW-1:0]] = '{wr: i_req_write, ds: i_req_dstore,
                                       bu: i_req_burst, ln: i_req_lanes,
                                       dat: i_req_data};
      end
      cnt_next   = cnt_after + CW'(push);
      ready_next = cnt_next != CW'(DEPTH);
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         cnt_reg     <= '0;
         o_req_ready <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            q_reg[i] <= '0;
         end
      end else begin
         cnt_reg     <= cnt_next;
         o_req_ready <= ready_next;
         q_reg       <= q_next;
      end
   end

   // Tenure sequencing
   dbtl_ten_s        cur_reg, cur_next;
   logic [DBTL_BEAT_W-1:0] beat_reg, beat_next, beat_last;
   logic             busy_reg, busy_next, boe_n_reg, boe_n_next;
   dbtl_dword_t      dout_reg, dout_next;
   dbtl_lanes_t      pout_reg, pout_next;
   logic             doe_n_reg, doe_n_next;
   logic             rdv_next, rdl_next, wrd_next;
   dbtl_dword_t      rdd_next;
   logic             perr_reg, perr_next, dpe_n_reg, mc_next;
   dbtl_lanes_t      chk;

   always_comb begin
      state_next = state_reg;
      cur_next   = cur_reg;
      beat_next  = beat_reg;
      busy_next  = busy_reg;
      boe_n_next = boe_n_reg;
      dout_next  = dout_reg;
      doe_n_next = doe_n_reg;
      rdv_next   = 1'b0;
      rdl_next   = 1'b0;
      rdd_next   = o_rd_data;
      wrd_next   = 1'b0;
      perr_next  = 1'b0;
      beat_last  = cur_reg.bu ? DBTL_BEAT_LAST_B : DBTL_BEAT_LAST_S;
      chk        = cur_reg.ds ? DBTL_CHK_HIGH : DBTL_CHK_ALL;
      unique case (state_reg)
         DEV_IDLE: begin
            boe_n_next = 1'b1;
            if (pop) begin
               cur_next   = q_reg[pick];
               beat_next  = DBTL_BEAT_FIRST;
               busy_next  = 1'b1;
               boe_n_next = 1'b0;
               state_next = DEV_XFER;
               if (q_reg[pick].wr) begin
                  dout_next  = dbtl_mask(q_reg[pick].dat[0], q_reg[pick].ln,
                                         q_reg[pick].ds);
                  doe_n_next = 1'b0;
               end
            end
         end
         DEV_XFER: begin
            if (bus.transfer_ack) begin
               if (cur_reg.wr) begin
                  wrd_next = beat_reg == beat_last;
               end else begin
                  rdv_next  = 1'b1;
                  rdd_next  = bus.data_bus;
                  rdl_next  = beat_reg == beat_last;
                  perr_next = i_parity_check_en &&
                              |(dbtl_par_bad(bus.data_bus,
                                             bus.data_byte_parity) & chk);
               end
               if (beat_reg == beat_last) begin
                  // Single clock: busy negates one cycle after the last ack
                  busy_next  = 1'b0;
                  doe_n_next = 1'b1;
                  state_next = DEV_RELEASE;
               end else begin
                  beat_next = beat_reg + 2'h1;
                  if (cur_reg.wr) begin
                     dout_next = dbtl_mask(cur_reg.dat[beat_reg + 2'h1],
                                           cur_reg.ln, cur_reg.ds);
                  end
               end
            end
         end
         DEV_RELEASE: begin
            boe_n_next = 1'b1;
            state_next = DEV_IDLE;
         end
         default: state_next = DEV_IDLE;
      endcase
      pout_next = dbtl_odd_par(dout_next);
      mc_next   = perr_reg;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_reg       <= DEV_IDLE;
         cur_reg         <= '0;
         beat_reg        <= DBTL_BEAT_FIRST;
         busy_reg        <= 1'b0;
         boe_n_reg       <= 1'b1;
         dout_reg        <= '0;
         pout_reg        <= '0;
         doe_n_reg       <= 1'b1;
         o_rd_valid      <= 1'b0;
         o_rd_data       <= '0;
         o_rd_last       <= 1'b0;
         o_wr_done       <= 1'b0;
         perr_reg        <= 1'b0;
         dpe_n_reg       <= 1'b1;
         o_machine_check <= 1'b0;
      end else begin
         state_reg       <= state_next;
         cur_reg         <= cur_next;
         beat_reg        <= beat_next;
         busy_reg        <= busy_next;
         boe_n_reg       <= boe_n_next;
         dout_reg        <= dout_next;
         pout_reg        <= pout_next;
         doe_n_reg       <= doe_n_next;
         o_rd_valid      <= rdv_next;
         o_rd_data       <= rdd_next;
         o_rd_last       <= rdl_next;
         o_wr_done       <= wrd_next;
         perr_reg        <= perr_next;
         dpe_n_reg       <= !perr_reg;
         o_machine_check <= mc_next;
      end
   end

   assign bus.dev_busy_out  = busy_reg;
   assign bus.dev_busy_oe_n = boe_n_reg;
   assign bus.dev_data      = dout_reg;
   assign bus.dev_par       = pout_reg;
   assign bus.dev_data_oe_n = doe_n_reg;
   assign bus.dev_dpe_oe_n  = dpe_n_reg;

endmodule : dbtl_device
`default_nettype wire

// >>> rtl/dbtl_pkg.sv
package dbtl_pkg;

   localparam int DBTL_LANES       = 8;
   localparam int DBTL_BURST_BEATS = 4;
   localparam int DBTL_BEAT_W      = 2;

   // Lane 0 is the most significant byte of the high half
   typedef logic [0:DBTL_LANES-1][7:0]            dbtl_dword_t;
   typedef logic [0:DBTL_LANES-1]                 dbtl_lanes_t;
   typedef logic [0:DBTL_BURST_BEATS-1][0:DBTL_LANES-1][7:0] dbtl_line_t;

   typedef struct packed {
      logic        wr;
      logic        ds;
      logic        bu;
      dbtl_lanes_t ln;
      dbtl_line_t  dat;
   } dbtl_ten_s;

   localparam logic [DBTL_BEAT_W-1:0] DBTL_BEAT_FIRST  = 2'h0;
   localparam logic [DBTL_BEAT_W-1:0] DBTL_BEAT_LAST_B = 2'h3;
   localparam logic [DBTL_BEAT_W-1:0] DBTL_BEAT_LAST_S = 2'h0;
   localparam logic [2:0]  DBTL_BEATS_BURST  = 3'h4;
   localparam logic [2:0]  DBTL_BEATS_SINGLE = 3'h1;
   localparam dbtl_lanes_t DBTL_CHK_ALL      = 8'hff;
   localparam dbtl_lanes_t DBTL_CHK_HIGH     = 8'hf0;
   localparam dbtl_lanes_t DBTL_PAR_FLIP     = 8'h80;

   function automatic dbtl_lanes_t dbtl_odd_par(input dbtl_dword_t d);
      dbtl_lanes_t p;
      for (int k = 0; k < DBTL_LANES; k++) begin
         p[k] = ~^d[k];
      end
      return p;
   endfunction : dbtl_odd_par

   function automatic dbtl_lanes_t dbtl_par_bad(input dbtl_dword_t d,
                                                input dbtl_lanes_t p);
      return ~(dbtl_odd_par(d) ~^ p);
   endfunction : dbtl_par_bad

   // Unselected lanes, and the low half on direct-store, drive zero
   function automatic dbtl_dword_t dbtl_mask(input dbtl_dword_t d,
                                             input dbtl_lanes_t ln,
                                             input logic        ds);
      dbtl_dword_t o;
      for (int k = 0; k < DBTL_LANES; k++) begin
         o[k] = (ln[k] && !(ds && k >= DBTL_LANES / 2)) ? d[k] : 8'h00;
      end
      return o;
   endfunction : dbtl_mask

endpackage : dbtl_pkg

// >>> rtl/dbtl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dbtl_if;
   import dbtl_pkg::*;

   logic        data_bus_grant;
   logic        write_reorder_allow;
   logic        transfer_ack;
   logic        data_retry;
   logic        address_retry;
   logic        dev_busy_out;
   logic        dev_busy_oe_n;
   logic        host_busy_out;
   logic        host_busy_oe_n;
   logic        data_bus_busy;
   dbtl_dword_t dev_data;
   dbtl_lanes_t dev_par;
   logic        dev_data_oe_n;
   dbtl_dword_t host_data;
   dbtl_lanes_t host_par;
   logic        host_data_oe_n;
   dbtl_dword_t data_bus;
   dbtl_lanes_t data_byte_parity;
   logic [31:0] data_high_half;
   logic [31:0] data_low_half;
   logic        dev_dpe_oe_n;
   logic        data_parity_error_out;

   // Wired level: an undriven line reads as negated (pull-up on the pin)
   assign data_bus_busy = (!dev_busy_oe_n && dev_busy_out) ||
                          (!host_busy_oe_n && host_busy_out);
   assign data_bus = !dev_data_oe_n ? dev_data :
                     (!host_data_oe_n ? host_data : '0);
   assign data_byte_parity = !dev_data_oe_n ? dev_par :
                             (!host_data_oe_n ? host_par : '0);
   assign data_high_half = data_bus[0:3];
   assign data_low_half  = data_bus[4:7];
   assign data_parity_error_out = !dev_dpe_oe_n;

   modport device (
      input  data_bus_grant, write_reorder_allow, transfer_ack,
      input  data_retry, address_retry, data_bus_busy,
      input  data_bus, data_byte_parity,
      output dev_busy_out, dev_busy_oe_n, dev_data, dev_par,
      output dev_data_oe_n, dev_dpe_oe_n
   );

   modport host (
      input  data_bus_busy, data_bus, dev_data_oe_n,
      input  data_parity_error_out,
      output data_bus_grant, write_reorder_allow, transfer_ack,
      output data_retry, address_retry, host_busy_out, host_busy_oe_n,
      output host_data, host_par, host_data_oe_n
   );

endinterface : dbtl_if
`default_nettype wire

// >>> rtl/dbtl_host.sv
`timescale 1ns/100ps
`default_nettype none
module dbtl_host
   import dbtl_pkg::*;
(
   // Clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_srst,
   // Grant control
   input  wire logic         i_grant_req,
   input  wire logic         i_grant_burst,
   input  wire logic         i_reorder,
   input  wire logic         i_foreign_busy,
   input  wire logic         i_data_retry,
   input  wire logic         i_address_retry,
   // Beat pacing and read data
   input  wire logic         i_ack_hold,
   input  wire dbtl_dword_t  i_rd_data,
   input  wire logic         i_bad_parity,
   // Results
   output logic              o_wr_valid,
   output dbtl_dword_t       o_wr_data,
   output logic              o_tenure_done,
   output logic              o_parity_error,
   // Bus
   dbtl_if.host              bus
);

   typedef enum logic [1:0] {HOST_IDLE, HOST_GRANT, HOST_XFER} dbtl_host_e;

   dbtl_host_e  state_reg, state_next;
   logic [2:0]  left_reg, left_next, left_after;
   logic        grant_reg, grant_next, reorder_reg, reorder_next;
   logic        ack_reg, ack_next, hoe_n_reg, hoe_n_next;
   dbtl_dword_t hdat_reg, hdat_next;
   dbtl_lanes_t hpar_reg, hpar_next;
   logic        wrv_next, done_next;
   dbtl_dword_t wrd_next;

   always_comb begin
      state_next   = state_reg;
      left_next    = left_reg;
      grant_next   = 1'b0;
      reorder_next = 1'b0;
      ack_next     = 1'b0;
      hoe_n_next   = 1'b1;
      hdat_next    = hdat_reg;
      hpar_next    = hpar_reg;
      wrv_next     = 1'b0;
      wrd_next     = o_wr_data;
      done_next    = 1'b0;
      left_after   = left_reg - {2'b00, ack_reg};
      unique case (state_reg)
         HOST_IDLE: begin
            if (i_grant_req && !bus.data_bus_busy && !i_foreign_busy) begin
               grant_next   = 1'b1;
               reorder_next = i_reorder;
               left_next    = i_grant_burst ? DBTL_BEATS_BURST
                                            : DBTL_BEATS_SINGLE;
               state_next   = HOST_GRANT;
            end
         end
         // Allow drops with the grant, long before the next one
         HOST_GRANT: state_next = HOST_XFER;
         HOST_XFER: begin
            if (ack_reg && !bus.dev_data_oe_n) begin
               wrv_next = 1'b1;
               wrd_next = bus.data_bus;
            end
            left_next = left_after;
            if (left_after == 3'h0) begin
               done_next  = 1'b1;
               state_next = HOST_IDLE;
            end else if (!bus.data_bus_busy) begin
               // Device had nothing pending or saw a retry, and let the grant pass
               state_next = HOST_IDLE;
            end else if (!i_ack_hold) begin
               ack_next = 1'b1;
               if (bus.dev_data_oe_n) begin
                  hoe_n_next = 1'b0;
                  hdat_next  = i_rd_data;
                  hpar_next  = dbtl_odd_par(i_rd_data) ^
                               (i_bad_parity ? DBTL_PAR_FLIP : '0);
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_reg           <= HOST_IDLE;
         left_reg            <= 3'h0;
         grant_reg           <= 1'b0;
         reorder_reg         <= 1'b0;
         ack_reg             <= 1'b0;
         hoe_n_reg           <= 1'b1;
         hdat_reg            <= '0;
         hpar_reg            <= '0;
         o_wr_valid          <= 1'b0;
         o_wr_data           <= '0;
         o_tenure_done       <= 1'b0;
         o_parity_error      <= 1'b0;
         bus.data_retry      <= 1'b0;
         bus.address_retry   <= 1'b0;
         bus.host_busy_out   <= 1'b0;
         bus.host_busy_oe_n  <= 1'b1;
      end else begin
         state_reg           <= state_next;
         left_reg            <= left_next;
         grant_reg           <= grant_next;
         reorder_reg         <= reorder_next;
         ack_reg             <= ack_next;
         hoe_n_reg           <= hoe_n_next;
         hdat_reg            <= hdat_next;
         hpar_reg            <= hpar_next;
         o_wr_valid          <= wrv_next;
         o_wr_data           <= wrd_next;
         o_tenure_done       <= done_next;
         o_parity_error      <= bus.data_parity_error_out;
         bus.data_retry      <= i_data_retry;
         bus.address_retry   <= i_address_retry;
         bus.host_busy_out   <= i_foreign_busy;
         bus.host_busy_oe_n  <= !i_foreign_busy;
      end
   end

   assign bus.data_bus_grant      = grant_reg;
   assign bus.write_reorder_allow = reorder_reg;
   assign bus.transfer_ack        = ack_reg;
   assign bus.host_data_oe_n      = hoe_n_reg;
   assign bus.host_data           = hdat_reg;
   assign bus.host_par            = hpar_reg;

endmodule : dbtl_host
`default_nettype wire

// >>> tb/dbtl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module dbtl_properties
   import dbtl_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // Arbitration and termination
   input  wire logic        data_bus_grant,
   input  wire logic        data_retry,
   input  wire logic        address_retry,
   input  wire logic        transfer_ack,
   input  wire logic        data_bus_busy,
   // Busy drivers
   input  wire logic        dev_busy_out,
   input  wire logic        dev_busy_oe_n,
   input  wire logic        host_busy_out,
   input  wire logic        host_busy_oe_n,
   // Device data drive
   input  wire dbtl_dword_t dev_data,
   input  wire dbtl_lanes_t dev_par,
   input  wire logic        dev_data_oe_n,
   input  wire logic        dev_dpe_oe_n
);
   dbtl_lanes_t par_ok;

   always_comb begin
      for (int k = 0; k < DBTL_LANES; k++) begin
         par_ok[k] = ^{dev_data[k], dev_par[k]};
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   a_busy_qualified: assert property (
      $fell(dev_busy_oe_n) |-> $past(data_bus_grant && !data_bus_busy
         && !data_retry && !address_retry))
      else $error("busy taken without a qualified grant");
   a_busy_asserted: assert property (
      $fell(dev_busy_oe_n) |-> dev_busy_out)
      else $error("busy not asserted when first driven");
   a_busy_negate: assert property (
      (!dev_busy_oe_n && !dev_busy_out
         && $past(dev_busy_out && !dev_busy_oe_n))
      |-> $past(transfer_ack) ##1 dev_busy_oe_n)
      else $error("busy negation or release mistimed");
   a_busy_release: assert property (
      $rose(dev_busy_oe_n) |-> $past(!dev_busy_out))
      else $error("busy released while asserted");
   a_data_start: assert property (
      $fell(dev_data_oe_n) |-> $fell(dev_busy_oe_n))
      else $error("write data not aligned with busy");
   a_beat_hold: assert property (
      (!dev_data_oe_n && $past(!dev_data_oe_n && !transfer_ack))
      |-> $stable(dev_data) && $stable(dev_par))
      else $error("write beat changed without ack");
   a_data_off: assert property (
      $rose(dev_data_oe_n) |-> $past(transfer_ack) && !dev_busy_oe_n)
      else $error("write data released at wrong time");
   a_parity_odd: assert property (
      !dev_data_oe_n |-> &par_ok)
      else $error("write lane parity not odd");
   a_dpe_delay: assert property (
      $fell(dev_dpe_oe_n) |-> $past(transfer_ack, 2))
      else $error("parity error pin not two clocks after ack");
   a_dpe_width: assert property (
      $fell(dev_dpe_oe_n) |=> dev_dpe_oe_n)
      else $error("parity error pin held too long");
   a_foreign_hold: assert property (
      (!host_busy_oe_n && host_busy_out && dev_busy_oe_n) |=> dev_busy_oe_n)
      else $error("device took bus under foreign busy");
endmodule : dbtl_properties
`default_nettype wire

// >>> tb/dbtl_test.sv
`timescale 1ns/100ps
`default_nettype none
module dbtl_test;
   import dbtl_pkg::*;

   // Flags: [5] write, [4] direct-store, [3] burst, [2] bad parity,
   // [1] check enable, [0] wait states
   typedef struct packed {
      logic [5:0]  fl;
      dbtl_lanes_t ln;
      logic [63:0] d;
   } dbtl_row_s;

   localparam int TIMEOUT = 20000;

   logic i_clock, i_srst, req_valid, req_write, req_dstore, req_burst;
   logic parity_check_en, grant_req, grant_burst, reorder, foreign_busy;
   logic data_retry, address_retry, bad_parity, hold_en;
   logic ack_hold = 1'b0;
   dbtl_lanes_t req_lanes, exp_ln;
   dbtl_line_t  req_data, exp_line;
   dbtl_dword_t rd_data, rd_seen, wr_seen, exp_rd;
   logic req_ready, rd_valid, rd_last, wr_done, machine_check;
   logic wr_valid, tenure_done, parity_error, exp_ds;
   int   fails = 0, checks = 0, cycles = 0;
   int   wr_n, rd_n, last_n, wd_n, mc_n, pe_n, done_n;
   logic order_q[$];

   dbtl_row_s rows [0:8] = '{
      '{6'h22, 8'hff, 64'h0123456789abcdef},
      '{6'h22, 8'ha5, 64'hfedcba9876543210},
      '{6'h2b, 8'hff, 64'h55aa33cc0ff0f00f},
      '{6'h32, 8'hff, 64'h1122334455667788},
      '{6'h02, 8'hff, 64'h8899aabbccddeeff},
      '{6'h0b, 8'hff, 64'h0f1e2d3c4b5a6978},
      '{6'h06, 8'hff, 64'h00ff00ff00ff00ff},
      '{6'h04, 8'hff, 64'h0000000000000001},
      '{6'h16, 8'hff, 64'h13572468aabbccdd}};

   dbtl_if bus_i ();

   dbtl_device #(.DEPTH(4)) dbtl_device_i (
      .i_clock(i_clock), .i_srst(i_srst), .i_req_valid(req_valid),
      .i_req_write(req_write), .i_req_dstore(req_dstore),
      .i_req_burst(req_burst), .i_req_lanes(req_lanes),
      .i_req_data(req_data), .o_req_ready(req_ready),
      .o_rd_valid(rd_valid), .o_rd_data(rd_seen), .o_rd_last(rd_last),
      .o_wr_done(wr_done), .i_parity_check_en(parity_check_en),
      .o_machine_check(machine_check), .bus(bus_i.device));

   dbtl_host dbtl_host_i (
      .i_clock(i_clock), .i_srst(i_srst), .i_grant_req(grant_req),
      .i_grant_burst(grant_burst), .i_reorder(reorder),
      .i_foreign_busy(foreign_busy), .i_data_retry(data_retry),
      .i_address_retry(address_retry), .i_ack_hold(ack_hold),
      .i_rd_data(rd_data), .i_bad_parity(bad_parity),
      .o_wr_valid(wr_valid), .o_wr_data(wr_seen),
      .o_tenure_done(tenure_done), .o_parity_error(parity_error),
      .bus(bus_i.host));

   dbtl_properties dbtl_properties_i (
      .i_clock(i_clock), .i_srst(i_srst),
      .data_bus_grant(bus_i.data_bus_grant),
      .data_retry(bus_i.data_retry), .address_retry(bus_i.address_retry),
      .transfer_ack(bus_i.transfer_ack),
      .data_bus_busy(bus_i.data_bus_busy),
      .dev_busy_out(bus_i.dev_busy_out),
      .dev_busy_oe_n(bus_i.dev_busy_oe_n),
      .host_busy_out(bus_i.host_busy_out),
      .host_busy_oe_n(bus_i.host_busy_oe_n), .dev_data(bus_i.dev_data),
      .dev_par(bus_i.dev_par), .dev_data_oe_n(bus_i.dev_data_oe_n),
      .dev_dpe_oe_n(bus_i.dev_dpe_oe_n));

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   function automatic dbtl_dword_t bmask(dbtl_dword_t d, dbtl_lanes_t ln,
                                         logic ds);
      for (int k = 0; k < 8; k++) begin
         if (!ln[k] || (ds && k > 3)) d[k] = 8'h00;
      end
      return d;
   endfunction : bmask

   function automatic dbtl_line_t line_of(logic [63:0] d);
      dbtl_line_t l;
      for (int k = 0; k < 4; k++) begin
         l[k] = d ^ {32{2'(k)}};
      end
      return l;
   endfunction : line_of

   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // Wait states on alternate cycles stress beat hold and advance
   always @(negedge i_clock) ack_hold <= hold_en & ~ack_hold;

   always @(posedge i_clock) begin
      if (wr_valid === 1'b1) begin
         check("wr_data", wr_seen,
               bmask(exp_line[wr_n[1:0]], exp_ln, exp_ds));
         wr_n++;
      end
      if (rd_valid === 1'b1) begin
         check("rd_data", bmask(rd_seen, 8'hff, exp_ds),
               bmask(exp_rd, 8'hff, exp_ds));
         rd_n++;
      end
      if (rd_last === 1'b1) order_q.push_back(1'b0);
      if (rd_last === 1'b1) last_n++;
      if (wr_done === 1'b1) order_q.push_back(1'b1);
      if (wr_done === 1'b1) wd_n++;
      if (machine_check === 1'b1) mc_n++;
      if (parity_error === 1'b1) pe_n++;
      if (tenure_done === 1'b1) done_n++;
      cycles++;
      if (cycles == TIMEOUT) begin
         fails++;
         finish_test();
      end
   end

   task automatic arm(dbtl_row_s r);
      @(negedge i_clock);
      exp_line = line_of(r.d);
      exp_ln = r.ln;
      exp_ds = r.fl[4];
      exp_rd = r.d;
      rd_data = r.d;
      bad_parity = r.fl[2];
      parity_check_en = r.fl[1];
      hold_en = r.fl[0];
      {wr_n, rd_n, last_n, wd_n, mc_n, pe_n} = '0;
      order_q.delete();
   endtask : arm

   task automatic send(dbtl_row_s r);
      int n;
      @(negedge i_clock);
      req_valid = 1'b1;
      {req_write, req_dstore, req_burst} = r.fl[5:3];
      req_lanes = r.ln;
      req_data = line_of(r.d);
      n = 0;
      @(posedge i_clock);
      while (req_ready !== 1'b1 && n < 100) begin
         n++;
         @(posedge i_clock);
      end
      @(negedge i_clock);
      req_valid = 1'b0;
   endtask : send

   task automatic tenures(int n, logic bu, logic ro);
      int t;
      int k;
      @(negedge i_clock);
      grant_req = 1'b1;
      grant_burst = bu;
      reorder = ro;
      t = done_n + n;
      k = 0;
      while (done_n < t && k < 300) begin
         k++;
         @(negedge i_clock);
      end
      grant_req = 1'b0;
      repeat (4) @(negedge i_clock);
   endtask : tenures

   task automatic do_reset();
      @(negedge i_clock);
      i_srst = 1'b1;
      grant_req = 1'b0;
      repeat (12) @(negedge i_clock);
      check("reset", {req_ready, bus_i.dev_busy_oe_n,
            bus_i.dev_data_oe_n, bus_i.dev_dpe_oe_n}, 4'h7);
      i_srst = 1'b0;
   endtask : do_reset

   initial begin
      {req_valid, req_write, req_dstore, req_burst, parity_check_en} = '0;
      {grant_req, grant_burst, reorder, foreign_busy, data_retry} = '0;
      {address_retry, bad_parity, hold_en} = '0;
      {req_lanes, req_data, rd_data} = '0;
      i_srst = 1'b1;
      do_reset();
      foreach (rows[i]) begin
         arm(rows[i]);
         send(rows[i]);
         tenures(1, rows[i].fl[3], 1'b0);
         check("beats", rows[i].fl[5] ? wr_n : rd_n,
               rows[i].fl[3] ? 4 : 1);
         check("done", rows[i].fl[5] ? wd_n : last_n, 1);
         check("mchk", mc_n, (rows[i].fl & 6'h26) == 6'h06);
         check("dpe", pe_n, (rows[i].fl & 6'h26) == 6'h06);
      end
      // Read queued ahead of write: allow decides who goes first
      for (int ro = 0; ro < 2; ro++) begin
         arm(rows[0]);
         exp_rd = rows[4].d;
         rd_data = rows[4].d;
         send(rows[4]);
         send(rows[0]);
         tenures(2, 1'b0, ro[0]);
         check("order", order_q.size() == 2 ? order_q[0] : 1'bx,
               ro[0]);
      end
      arm(rows[4]);
      send(rows[4]);
      tenures(1, 1'b0, 1'b1);
      check("allow_no_write", last_n, 1);
      // Foreign busy, data retry, address retry each hold the device off
      for (int b = 0; b < 3; b++) begin
         arm(rows[1]);
         {foreign_busy, data_retry, address_retry} = 3'h4 >> b;
         grant_req = 1'b1;
         send(rows[1]);
         repeat (20) @(negedge i_clock);
         check("blocked", wd_n, 0);
         {foreign_busy, data_retry, address_retry} = 3'h0;
         tenures(1, 1'b0, 1'b0);
         check("unblocked", wd_n, 1);
      end
      // Reset in mid-burst, then the block must work again
      arm(rows[2]);
      send(rows[2]);
      grant_req = 1'b1;
      grant_burst = 1'b1;
      repeat (4) @(negedge i_clock);
      do_reset();
      arm(rows[0]);
      send(rows[0]);
      tenures(1, 1'b0, 1'b0);
      check("after_reset", wd_n, 1);
      finish_test();
   end
endmodule : dbtl_test
`default_nettype wire
